//--- hdl/ccc_command_control.sv
// command-control register bank: state machine, abort and launch registers
// assumes synchronous inputs, one clock, a master that never waits
//
// Contract
// - idle indicator readable and valid within field-valid timeout after init
// - idle indicator is 1 in Idle and only in Idle
// - idle indicator resets to the Idle value
// - ready request clears idle indicator, enters Ready within state-change timeout
// - fatal flag set only by unreportable fatal error; the code also sets it on a control-register write of the FERR bit
// - fatal flag reflects operational state and is valid after init
// - abort in execution may stop command; response and completion follow
// - finished command returns normal code, terminated one the cancelled code
// - aborted command ends within the long-command timeout
// - ending under abort clears the whole launch register
// - abort register ignored outside Command Execution
// - abort register is 32-bit read/write, resets to zero
// - abort sampled during execution; an uncleared abort hits the next command
// - preemption in execution acts as abort then go to Idle
// - launch write of one in Reception starts execution
// - launch write of one ignored outside Reception
// - launch write of zero ignored entirely
// - end of processing clears launch and enters Completion
// - go-idle request invalidates buffer, enters Idle, sets idle indicator
// - first command byte written in Ready enters Reception
// - device is in Idle after init
`timescale 1ns/1ps
`default_nettype none

module ccc_command_control
  import ccc_pkg::*;
#(
  parameter int EXEC_CYC      = 64,     // nominal command run time
  parameter int LONG_CMD_CYC  = 50000   // long-command timeout in cycles
)(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // command engine events
  input  wire logic        buf_first_byte,
  input  wire logic        fatal_event,
  input  wire logic        preempt_req,
  // status out
  output logic             idle_indicator,
  output logic             fatal_error_flag,
  output logic [2:0]       ccc_state,
  output logic [31:0]      response_code,
  output logic             response_valid,
  output logic             buffer_valid
);

  // ****************************************************************
  // state registers
  // ****************************************************************
  ccc_st_type  s_reg;
  ccc_st_type  s_next;
  ccc_bus_type bus;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // decoded write hits
  logic wr_req;
  logic wr_abort;
  logic wr_launch;
  logic wr_ctrl;
  logic abort_seen;
  logic preempt_seen;
  logic cmd_end;
  logic cmd_term;

  assign wr_req    = bus.wr && (bus.addr == CCC_OFF_REQ);
  assign wr_abort  = bus.wr && (bus.addr == CCC_OFF_ABORT);
  assign wr_launch = bus.wr && (bus.addr == CCC_OFF_LAUNCH);
  assign wr_ctrl   = bus.wr && (bus.addr == CCC_OFF_CTRL);

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  // abort only looked at during execution, so a stale value elsewhere is harmless
  always_comb
  begin
    s_next       = s_reg;
    abort_seen   = (s_reg.state == CCC_EXEC) && (s_reg.abort_req == CCC_WORD_ONE);
    preempt_seen = (s_reg.state == CCC_EXEC) && preempt_req;
    cmd_term     = abort_seen || preempt_seen;
    cmd_end      = (s_reg.state == CCC_EXEC) &&
                   (cmd_term || (s_reg.exec_cnt >= CCC_CNT_W'(EXEC_CYC)));
    s_next.exec_go = 1'b0;

    // abort register stores whatever is written
    if (wr_abort)
    begin
      s_next.abort_req = bus.wdata;
    end

    // sticky fatal flag, from an unreportable error or a control write of the FERR bit
    if (fatal_event || (wr_ctrl && bus.wdata[CCC_BIT_FERR]))
    begin
      s_next.fatal = 1'b1;
    end

    case (s_reg.state)
      CCC_IDLE:
      begin
        if (wr_req && bus.wdata[CCC_BIT_READY])
        begin
          s_next.state    = CCC_READY;
          s_next.idle_ind = 1'b0;
        end
      end
      CCC_READY:
      begin
        if (wr_req && bus.wdata[CCC_BIT_GO_IDLE_REQUEST])
        begin
          s_next.state     = CCC_IDLE;
          s_next.idle_ind  = 1'b1;
          s_next.buf_valid = 1'b0;
        end
        else if (buf_first_byte)
        begin
          s_next.state      = CCC_RECV;
          s_next.buf_valid  = 1'b1;
          s_next.resp_valid = 1'b0;
        end
      end
      CCC_RECV:
      begin
        if (wr_req && bus.wdata[CCC_BIT_GO_IDLE_REQUEST])
        begin
          s_next.state     = CCC_IDLE;
          s_next.idle_ind  = 1'b1;
          s_next.buf_valid = 1'b0;
        end
        else if (wr_launch && (bus.wdata == CCC_WORD_ONE))
        begin
          s_next.state    = CCC_EXEC;
          s_next.launch   = CCC_WORD_ONE;
          s_next.exec_cnt = '0;
          s_next.exec_go  = 1'b1;
        end
      end
      CCC_EXEC:
      begin
        s_next.exec_cnt = s_reg.exec_cnt + CCC_CNT_W'(1);
        if (cmd_end)
        begin
          s_next.launch     = CCC_WORD_ZERO;
          s_next.resp_valid = 1'b1;
          s_next.resp_code  = cmd_term ? CCC_RC_CANCEL : CCC_RC_OK;
          if (preempt_seen)
          begin
            s_next.state     = CCC_IDLE;
            s_next.idle_ind  = 1'b1;
            s_next.buf_valid = 1'b0;
          end
          else
          begin
            s_next.state = CCC_DONE;
          end
        end
      end
      CCC_DONE:
      begin
        if (wr_req && bus.wdata[CCC_BIT_GO_IDLE_REQUEST])
        begin
          s_next.state      = CCC_IDLE;
          s_next.idle_ind   = 1'b1;
          s_next.buf_valid  = 1'b0;
          s_next.resp_valid = 1'b0;
        end
      end
      default:
      begin
        s_next.state    = CCC_IDLE;
        s_next.idle_ind = 1'b1;
      end
    endcase

    // launch writes outside reception, and zero writes, leave everything alone

    // read data stands one cycle after the strobe; unmapped reads give zero
    s_next.rdata = CCC_WORD_ZERO;
    if (bus.rd)
    begin
      case (bus.addr)
        CCC_OFF_STS:
        begin
          s_next.rdata[CCC_BIT_IDLE]  = s_reg.idle_ind;
          s_next.rdata[CCC_BIT_FATAL] = s_reg.fatal;
        end
        CCC_OFF_ABORT:  s_next.rdata = s_reg.abort_req;
        CCC_OFF_LAUNCH: s_next.rdata = s_reg.launch;
        CCC_OFF_CTRL:   s_next.rdata[CCC_BIT_FERR] = s_reg.fatal;
        default:        s_next.rdata = CCC_WORD_ZERO;
      endcase
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // reset lands in Idle with the indicator set, so reads are valid at once
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_reg            <= '0;
      s_reg.state      <= CCC_IDLE;
      s_reg.idle_ind   <= 1'b1;
    end
    else if (clk_en)
    begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flops
  assign reg_rdata        = s_reg.rdata;
  assign idle_indicator   = s_reg.idle_ind;
  assign fatal_error_flag = s_reg.fatal;
  assign ccc_state        = s_reg.state;
  assign response_code    = s_reg.resp_code;
  assign response_valid   = s_reg.resp_valid;
  assign buffer_valid     = s_reg.buf_valid;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_idle_only_idle: assert property (
    idle_indicator == (s_reg.state == CCC_IDLE))
    else $error("idle indicator out of step with state");

  chk_ready_request: assert property (
    (clk_en && s_reg.state == CCC_IDLE && wr_req && reg_wdata[CCC_BIT_READY])
      |=> (!idle_indicator && s_reg.state == CCC_READY))
    else $error("ready request not taken");

  chk_launch_start: assert property (
    (clk_en && s_reg.state == CCC_RECV && wr_launch && reg_wdata == CCC_WORD_ONE
      && !(wr_req && reg_wdata[CCC_BIT_GO_IDLE_REQUEST]))
      |=> (s_reg.state == CCC_EXEC && s_reg.launch == CCC_WORD_ONE))
    else $error("launch did not start execution");

  chk_launch_ignored: assert property (
    (clk_en && s_reg.state != CCC_RECV && s_reg.state != CCC_EXEC) |=>
      s_reg.launch == CCC_WORD_ZERO)
    else $error("launch register moved outside reception");

  chk_abort_ends: assert property (
    (clk_en && s_reg.state == CCC_EXEC && s_reg.abort_req == CCC_WORD_ONE && !preempt_req)
      |=> (s_reg.state == CCC_DONE && s_reg.launch == CCC_WORD_ZERO
           && response_code == CCC_RC_CANCEL))
    else $error("abort did not end command");

  chk_completion_clear: assert property (
    (s_reg.state == CCC_DONE) |-> (s_reg.launch == CCC_WORD_ZERO && response_valid))
    else $error("completion without cleared launch");

  chk_abort_readback: assert property (
    (clk_en && wr_abort) ##1 (clk_en && reg_rd && reg_addr == CCC_OFF_ABORT && !wr_abort)
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("abort readback wrong");

  chk_fatal_cause: assert property (
    $rose(fatal_error_flag) |-> $past(fatal_event || (wr_ctrl && reg_wdata[CCC_BIT_FERR])))
    else $error("fatal flag rose without cause");

  chk_go_idle_request_done: assert property (
    (clk_en && s_reg.state == CCC_DONE && wr_req && reg_wdata[CCC_BIT_GO_IDLE_REQUEST])
      |=> (idle_indicator && !buffer_valid))
    else $error("go idle not taken");

  // ****************************************************************
  // checks on transitions and on the register port
  // ****************************************************************
  // reset must leave the machine idle with both words cleared
  chk_reset_state: assert property (
    $past(rst) |-> (idle_indicator && s_reg.state == CCC_IDLE
      && s_reg.abort_req == CCC_WORD_ZERO && s_reg.launch == CCC_WORD_ZERO))
    else $error("state after reset not idle");

  // go idle is also honoured before a command has been launched
  chk_go_idle_request_early: assert property (
    (clk_en && (s_reg.state == CCC_READY || s_reg.state == CCC_RECV)
      && wr_req && reg_wdata[CCC_BIT_GO_IDLE_REQUEST])
      |=> (s_reg.state == CCC_IDLE && idle_indicator && !buffer_valid))
    else $error("early go idle not taken");

  // first command byte moves ready into reception
  chk_recv_entry: assert property (
    (clk_en && s_reg.state == CCC_READY && buf_first_byte
      && !(wr_req && reg_wdata[CCC_BIT_GO_IDLE_REQUEST]))
      |=> (s_reg.state == CCC_RECV && buffer_valid))
    else $error("first byte did not open reception");

  // a zero launch in reception must leave state and word alone
  chk_launch_zero: assert property (
    (clk_en && s_reg.state == CCC_RECV && wr_launch && reg_wdata == CCC_WORD_ZERO)
      |=> (s_reg.state == CCC_RECV && s_reg.launch == CCC_WORD_ZERO))
    else $error("zero launch was not ignored");

  // launch word reads one for the whole run, so polling software waits
  chk_launch_held: assert property (
    (s_reg.state == CCC_EXEC) |-> (s_reg.launch == CCC_WORD_ONE))
    else $error("launch word dropped during execution");

  // start marker only in the first execution cycle
  chk_exec_first: assert property (
    s_reg.exec_go |-> (s_reg.state == CCC_EXEC && s_reg.exec_cnt == '0))
    else $error("start marker outside first execution cycle");

  // run length never reaches the long-command deadline; a run length
  // set at or above the deadline is a parameter error and shows up here
  chk_exec_bound: assert property (
    (s_reg.state == CCC_EXEC) |-> (s_reg.exec_cnt < CCC_CNT_W'(LONG_CMD_CYC)))
    else $error("execution ran past the long-command deadline");

  // an undisturbed run ends normally once its count is reached
  chk_normal_end: assert property (
    (clk_en && s_reg.state == CCC_EXEC && s_reg.abort_req != CCC_WORD_ONE && !preempt_req
      && s_reg.exec_cnt >= CCC_CNT_W'(EXEC_CYC))
      |=> (s_reg.state == CCC_DONE && response_valid && response_code == CCC_RC_OK
           && s_reg.launch == CCC_WORD_ZERO))
    else $error("normal run did not complete");

  // preemption cancels and drops straight to idle
  chk_preempt_idle: assert property (
    (clk_en && s_reg.state == CCC_EXEC && preempt_req)
      |=> (s_reg.state == CCC_IDLE && idle_indicator && response_code == CCC_RC_CANCEL
           && s_reg.launch == CCC_WORD_ZERO))
    else $error("preemption did not cancel to idle");

  // abort word only moves on a write to it
  chk_abort_held: assert property (
    (clk_en && !wr_abort) |=> $stable(s_reg.abort_req))
    else $error("abort word moved without a write");

  // status read reflects both indicators of the strobe cycle
  chk_status_read: assert property (
    (clk_en && reg_rd && reg_addr == CCC_OFF_STS)
      |=> (reg_rdata[CCC_BIT_IDLE] == $past(idle_indicator)
           && reg_rdata[CCC_BIT_FATAL] == $past(fatal_error_flag)))
    else $error("status read wrong");

  // launch read returns the word of the strobe cycle
  chk_launch_read: assert property (
    (clk_en && reg_rd && reg_addr == CCC_OFF_LAUNCH) |=> reg_rdata == $past(s_reg.launch))
    else $error("launch read wrong");

  // fatal flag is sticky until reset
  chk_fatal_sticky: assert property (
    fatal_error_flag |=> fatal_error_flag)
    else $error("fatal flag cleared without reset");

  cov_full_cycle: cover property (s_reg.state == CCC_EXEC ##[1:100] s_reg.state == CCC_DONE);
  cov_abort:      cover property (s_reg.state == CCC_EXEC && s_reg.abort_req == CCC_WORD_ONE);
  cov_preempt:    cover property (s_reg.state == CCC_EXEC && preempt_req);
  cov_back_idle:  cover property (s_reg.state == CCC_DONE ##1 s_reg.state == CCC_IDLE);

endmodule : ccc_command_control

`default_nettype wire

//--- hdl/ccc_pkg.sv
// package for the command-control register bank
// assumes a 50 MHz system clock and a plain strobe register port
package ccc_pkg;

  // ****************************************************************
  // register map, word offsets on the plain port
  // ****************************************************************
  localparam logic [3:0] CCC_OFF_REQ    = 4'h0;
  localparam logic [3:0] CCC_OFF_STS    = 4'h1;
  localparam logic [3:0] CCC_OFF_ABORT  = 4'h2;
  localparam logic [3:0] CCC_OFF_LAUNCH = 4'h3;
  localparam logic [3:0] CCC_OFF_CTRL   = 4'h4;

  // ****************************************************************
  // field positions and values
  // ****************************************************************
  localparam int          CCC_BIT_READY   = 0;
  localparam int          CCC_BIT_GO_IDLE_REQUEST  = 1;
  localparam int          CCC_BIT_FATAL   = 0;
  localparam int          CCC_BIT_IDLE    = 1;
  localparam int          CCC_BIT_PREEMPT = 0;
  localparam int          CCC_BIT_FERR    = 1;
  localparam logic [31:0] CCC_WORD_ZERO   = 32'h0000_0000;
  localparam logic [31:0] CCC_WORD_ONE    = 32'h0000_0001;
  localparam logic [31:0] CCC_RC_OK       = 32'h0000_0000;
  localparam logic [31:0] CCC_RC_CANCEL   = 32'h0000_0901; // arbitrary code

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CCC_CLK_MHZ       = 50;
  localparam int CCC_VALID_NS      = 100;
  localparam int CCC_CHANGE_NS     = 200;
  localparam int CCC_VALID_CYC     = (CCC_VALID_NS * CCC_CLK_MHZ) / 1000;
  localparam int CCC_CHANGE_CYC    = (CCC_CHANGE_NS * CCC_CLK_MHZ) / 1000;
  localparam int CCC_CNT_W         = 16;

  // ****************************************************************
  // states and carriers
  // ****************************************************************
  typedef enum logic [2:0] {
    CCC_IDLE  = 3'b000,
    CCC_READY = 3'b001,
    CCC_RECV  = 3'b010,
    CCC_EXEC  = 3'b011,
    CCC_DONE  = 3'b100
  } ccc_state_type;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ccc_bus_type;

  typedef struct packed {
    ccc_state_type          state;
    logic [31:0]            abort_req;
    logic [31:0]            launch;
    logic                   fatal;
    logic                   idle_ind;
    logic [31:0]            rdata;
    logic [31:0]            resp_code;
    logic                   resp_valid;
    logic                   buf_valid;
    logic                   exec_go;
    logic [CCC_CNT_W-1:0]   exec_cnt;
  } ccc_st_type;

endpackage : ccc_pkg

//--- verification/ccc_command_control_tb_top.sv
// self-checking bench for the command-control register bank
// assumes the bench alone drives every port of the design, one 50 MHz clock
`timescale 1ns/1ps
`default_nettype none

module ccc_command_control_tb_top
  import ccc_pkg::*;
;
  // ****************************************************************
  // signals and design
  // ****************************************************************
  localparam int EXEC_CYC = 8;
  localparam int LONG_CYC = 100;

  logic        clk_sys        = 1'b0;
  logic        rst            = 1'b1;
  logic        clk_en         = 1'b1;
  logic [3:0]  reg_addr       = 4'h0;
  logic [31:0] reg_wdata      = 32'h0000_0000;
  logic        reg_wr         = 1'b0;
  logic        reg_rd         = 1'b0;
  logic        buf_first_byte = 1'b0;
  logic        fatal_event    = 1'b0;
  logic        preempt_req    = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] response_code;
  logic [31:0] rd_val;
  logic [2:0]  ccc_state;
  logic        idle_indicator;
  logic        fatal_error_flag;
  logic        response_valid;
  logic        buffer_valid;
  int          n_fail         = 0;
  int          compares       = 0;
  int          cycles         = 0;

  ccc_command_control #(.EXEC_CYC(EXEC_CYC), .LONG_CMD_CYC(LONG_CYC)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .buf_first_byte(buf_first_byte), .fatal_event(fatal_event), .preempt_req(preempt_req),
    .idle_indicator(idle_indicator), .fatal_error_flag(fatal_error_flag),
    .ccc_state(ccc_state), .response_code(response_code),
    .response_valid(response_valid), .buffer_valid(buffer_valid));

  // ****************************************************************
  // clock, watchdog and helper tasks
  // ****************************************************************
  always #10 clk_sys = ~clk_sys;

  // the whole run needs well under a thousand cycles; a hang ends here
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      results();
    end
  end

  task automatic results();
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one-cycle write strobe; the design takes it at the next edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    @(negedge clk_sys);
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    rd_val = reg_rdata;
  endtask : rd

  // write then read back at once, no gap between the two strobes
  task automatic wr_rd(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge clk_sys);
    reg_rd    <= 1'b0;
    @(negedge clk_sys);
    rd_val = reg_rdata;
  endtask : wr_rd

  // software side: read the launch word until it drops, bounded
  task automatic poll_launch(input int lim);
    int k;
    k = 0;
    rd(CCC_OFF_LAUNCH);
    while (rd_val !== CCC_WORD_ZERO && k < lim)
    begin
      rd(CCC_OFF_LAUNCH);
      k++;
    end
  endtask : poll_launch

  // bounded wait for a state; missing the bound is a mismatch
  task automatic wait_state(input logic [2:0] s, input int lim);
    int k;
    k = 0;
    while (ccc_state !== s && k < lim)
    begin
      @(negedge clk_sys);
      k++;
    end
    check(32'(ccc_state), 32'(s));
  endtask : wait_state

  // idle to execution; a zero launch in reception must change nothing
  task automatic to_exec();
    wr(CCC_OFF_REQ, CCC_WORD_ONE);
    wait_state(CCC_READY, CCC_CHANGE_CYC);
    @(posedge clk_sys);
    buf_first_byte <= 1'b1;
    @(posedge clk_sys);
    buf_first_byte <= 1'b0;
    @(negedge clk_sys);
    wait_state(CCC_RECV, 2);
    check(32'(buffer_valid), 32'h1);
    wr(CCC_OFF_LAUNCH, CCC_WORD_ZERO);
    check(32'(ccc_state), 32'(CCC_RECV));
    wr(CCC_OFF_LAUNCH, CCC_WORD_ONE);
    check(32'(ccc_state), 32'(CCC_EXEC));
  endtask : to_exec

  task automatic go_idle();
    wr(CCC_OFF_REQ, 32'h0000_0002);
    wait_state(CCC_IDLE, CCC_CHANGE_CYC);
    check(32'(idle_indicator), 32'h1);
  endtask : go_idle

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check(32'(idle_indicator), 32'h1);
    wait_state(CCC_IDLE, CCC_VALID_CYC);
    rd(CCC_OFF_STS);
    check(rd_val, 32'h0000_0002);
    rd(CCC_OFF_ABORT);
    check(rd_val, CCC_WORD_ZERO);
    rd(CCC_OFF_LAUNCH);
    check(rd_val, CCC_WORD_ZERO);
    // launch and abort outside their states leave the machine alone
    wr(CCC_OFF_LAUNCH, CCC_WORD_ONE);
    rd(CCC_OFF_LAUNCH);
    check(rd_val, CCC_WORD_ZERO);
    wr_rd(CCC_OFF_ABORT, CCC_WORD_ONE);
    check(32'(ccc_state), 32'(CCC_IDLE));
    check(rd_val, CCC_WORD_ONE);
    wr(CCC_OFF_ABORT, CCC_WORD_ZERO);
    // a write with the clock enable low is not taken
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(CCC_OFF_REQ, CCC_WORD_ONE);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    @(negedge clk_sys);
    check(32'(ccc_state), 32'(CCC_IDLE));
    // go idle straight from ready, before any command
    wr(CCC_OFF_REQ, CCC_WORD_ONE);
    wait_state(CCC_READY, CCC_CHANGE_CYC);
    check(32'(idle_indicator), 32'h0);
    go_idle();
    // normal command
    to_exec();
    check(32'(idle_indicator), 32'h0);
    rd(CCC_OFF_LAUNCH);
    check(rd_val, CCC_WORD_ONE);
    poll_launch(EXEC_CYC + 4);
    check(rd_val, CCC_WORD_ZERO);
    wait_state(CCC_DONE, EXEC_CYC + 4);
    rd(CCC_OFF_LAUNCH);
    check(rd_val, CCC_WORD_ZERO);
    check(response_code, CCC_RC_OK);
    check(32'(response_valid), 32'h1);
    go_idle();
    check(32'(buffer_valid), 32'h0);
    // aborted command, abort left set so the next one is hit too
    to_exec();
    wr(CCC_OFF_ABORT, CCC_WORD_ONE);
    wait_state(CCC_DONE, LONG_CYC);
    check(response_code, CCC_RC_CANCEL);
    check(32'(response_valid), 32'h1);
    rd(CCC_OFF_LAUNCH);
    check(rd_val, CCC_WORD_ZERO);
    go_idle();
    to_exec();
    wait_state(CCC_DONE, 4);
    check(response_code, CCC_RC_CANCEL);
    wr(CCC_OFF_ABORT, CCC_WORD_ZERO);
    go_idle();
    // preemption in execution cancels and drops to idle
    to_exec();
    @(posedge clk_sys);
    preempt_req <= 1'b1;
    @(negedge clk_sys);
    wait_state(CCC_IDLE, LONG_CYC);
    check(response_code, CCC_RC_CANCEL);
    @(posedge clk_sys);
    preempt_req <= 1'b0;
    // fatal flag raised by an unreportable error
    check(32'(fatal_error_flag), 32'h0);
    @(posedge clk_sys);
    fatal_event <= 1'b1;
    @(posedge clk_sys);
    fatal_event <= 1'b0;
    rd(CCC_OFF_STS);
    check(rd_val, 32'h0000_0003);
    rd(CCC_OFF_CTRL);
    check(rd_val, 32'h0000_0002);
    results();
  end

endmodule : ccc_command_control_tb_top

`default_nettype wire
